// file: rtl/dwl_consts.svh
// Constants for the doubleword load decoder: opcodes, field positions and widths.
`ifndef DWL_CONSTS_SVH
`define DWL_CONSTS_SVH
`define DWL_OP_DS      6'h3A
`define DWL_OP_XFORM   6'h1F
`define DWL_OP_FPD     6'h32
`define DWL_OP_FPDU    6'h33
`define DWL_XO_LDUX    10'h035
`define DWL_XO_LDX     10'h015
`define DWL_XO_FPDUX   10'h277
`define DWL_DS_PLAIN   2'h0
`define DWL_DS_UPDATE  2'h1
`define DWL_DS_SCALE   2
`define DWL_FD_OP_HI   31
`define DWL_FD_OP_LO   26
`define DWL_FD_TGT_HI  25
`define DWL_FD_TGT_LO  21
`define DWL_FD_BASE_HI 20
`define DWL_FD_BASE_LO 16
`define DWL_FD_IDX_HI  15
`define DWL_FD_IDX_LO  11
`define DWL_FD_XO_HI   10
`define DWL_FD_XO_LO   1
`define DWL_FD_DS_HI   15
`define DWL_FD_DS_LO   2
`define DWL_FD_DSX_HI  1
`define DWL_FD_DSX_LO  0
`define DWL_FD_D_HI    15
`define DWL_FD_D_LO    0
`endif

// file: rtl/dwl_pkg.sv
// Types shared by the doubleword load decoder modules.
package dwl_pkg;
	typedef logic [63:0] dwl_word_t;
	typedef logic [4:0]  dwl_reg_t;
	typedef enum logic [2:0] {
		DWL_K_NONE  = 3'h0,
		DWL_K_LD    = 3'h1,
		DWL_K_LDU   = 3'h2,
		DWL_K_LDUX  = 3'h3,
		DWL_K_LDX   = 3'h4,
		DWL_K_FPD   = 3'h5,
		DWL_K_FPDU  = 3'h6,
		DWL_K_FPDUX = 3'h7
	} dwl_kind_e;
	typedef enum logic [1:0] {
		DWL_S_IDLE = 2'h0,
		DWL_S_READ = 2'h1,
		DWL_S_DONE = 2'h2
	} dwl_state_e;
endpackage

// file: rtl/dwl_dec_if.sv
// Decoded-instruction bundle passed from the decoder to the execution core.
`timescale 1ns/1ps
interface dwl_dec_if;
	import dwl_pkg::*;
	dwl_kind_e kind;
	logic      illegal;
	logic      invalid;
	logic      fpTarget;
	logic      wantUpdate;
	logic      baseZero;
	dwl_reg_t  targetGprField;
	dwl_reg_t  baseGprField;
	dwl_reg_t  indexGprField;
	dwl_word_t disp;
	logic      useIndex;
	modport dec (output kind, illegal, invalid, fpTarget, wantUpdate, baseZero, targetGprField,
		baseGprField, indexGprField, disp, useIndex);
	modport exe (input kind, illegal, invalid, fpTarget, wantUpdate, baseZero, targetGprField,
		baseGprField, indexGprField, disp, useIndex);
endinterface

// file: rtl/dwl_decode.sv
// Combinational decoder for the seven doubleword load instructions.
`timescale 1ns/1ps
`include "dwl_consts.svh"
module dwl_decode
	import dwl_pkg::*;
(
	// Instruction and implementation mode.
	input  wire logic [31:0] instr,
	input  wire logic        mode64,
	// Decoded fields.
	dwl_dec_if.dec           dec
);
	logic [5:0]  opcode;
	logic [9:0]  xo;
	logic [1:0]  dsx;
	dwl_kind_e   kind;

	// Displacement forms share one sign extender; the DWL_OP_DS opcode selects the scaled field.
	function automatic dwl_word_t sext16(input logic [15:0] v);
		return {{48{v[15]}}, v};
	endfunction

	always_comb begin
		opcode = instr[`DWL_FD_OP_HI:`DWL_FD_OP_LO];
		xo     = instr[`DWL_FD_XO_HI:`DWL_FD_XO_LO];
		dsx    = instr[`DWL_FD_DSX_HI:`DWL_FD_DSX_LO];
		kind   = DWL_K_NONE;
		if (opcode == `DWL_OP_DS && dsx == `DWL_DS_PLAIN)
			kind = DWL_K_LD;
		else if (opcode == `DWL_OP_DS && dsx == `DWL_DS_UPDATE)
			kind = DWL_K_LDU;
		else if (opcode == `DWL_OP_FPD)
			kind = DWL_K_FPD;
		else if (opcode == `DWL_OP_FPDU)
			kind = DWL_K_FPDU;
		else if (opcode == `DWL_OP_XFORM && xo == `DWL_XO_LDUX)
			kind = DWL_K_LDUX;
		else if (opcode == `DWL_OP_XFORM && xo == `DWL_XO_LDX)
			kind = DWL_K_LDX;
		else if (opcode == `DWL_OP_XFORM && xo == `DWL_XO_FPDUX)
			kind = DWL_K_FPDUX;
	end

	assign dec.kind           = kind;
	assign dec.targetGprField = instr[`DWL_FD_TGT_HI:`DWL_FD_TGT_LO];
	assign dec.baseGprField   = instr[`DWL_FD_BASE_HI:`DWL_FD_BASE_LO];
	assign dec.indexGprField  = instr[`DWL_FD_IDX_HI:`DWL_FD_IDX_LO];
	assign dec.baseZero       = (dec.baseGprField == 5'h00);
	assign dec.fpTarget       = (kind == DWL_K_FPD) || (kind == DWL_K_FPDU) ||
		(kind == DWL_K_FPDUX);
	assign dec.useIndex       = (kind == DWL_K_LDX) || (kind == DWL_K_LDUX) ||
		(kind == DWL_K_FPDUX);
	assign dec.wantUpdate     = (kind == DWL_K_LDU) || (kind == DWL_K_LDUX) ||
		(kind == DWL_K_FPDU) || (kind == DWL_K_FPDUX);
	// Fixed-point doubleword loads need a 64-bit implementation.
	assign dec.illegal        = !mode64 && ((kind == DWL_K_LD) || (kind == DWL_K_LDU) ||
		(kind == DWL_K_LDUX) || (kind == DWL_K_LDX));
	// Fixed-point update forms with base zero or base equal to target are invalid.
	assign dec.invalid        = ((kind == DWL_K_LDU) || (kind == DWL_K_LDUX)) &&
		(dec.baseZero || dec.baseGprField == dec.targetGprField);
	// Scaled field: sign-extend 14 bits to 64, times four; others: 16-bit sign extension.
	assign dec.disp           = (opcode == `DWL_OP_DS)
		? (sext16({{2{instr[`DWL_FD_DS_HI]}}, instr[`DWL_FD_DS_HI:`DWL_FD_DS_LO]})
			<< `DWL_DS_SCALE)
		: sext16(instr[`DWL_FD_D_HI:`DWL_FD_D_LO]);
endmodule // dwl_decode

// file: rtl/dwl_load_unit.sv
// Doubleword load unit: decode, address, storage read and register writeback.
//
// What this block does
// - Fixed-point scaled displacement: 14-bit signed field, sign-extended to 64, times four.
// - Fixed-point update load reads the doubleword at base plus displacement into target GPR.
// - Fixed-point displacement update load is invalid when base is zero or equals target.
// - Fixed-point doubleword loads exist only in 64-bit mode; otherwise raise illegal instruction.
// - Indexed update load adds base and index, loads target, writes address into base.
// - Indexed update load is invalid when base is zero or equals target.
// - Indexed load address is base plus index, or index alone when base field is zero.
// - Floating displacement load address is base plus signed displacement, or displacement alone.
// - Floating displacement and update loads leave float status and condition field 0 alone.
// - Floating update load address is base plus displacement, or displacement when base zero.
// - Floating update load writes base only if base nonzero and no access interrupt.
// - Floating indexed update address is base plus index, or index alone when base zero.
// - Floating indexed update writes base only if base nonzero and no access interrupt.
`timescale 1ns/1ps
`include "dwl_consts.svh"
module dwl_load_unit
	import dwl_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        resetn,
	// Issue port from the pipeline.
	input  wire logic        issueValid,
	output logic             issueReady,
	input  wire logic [31:0] instr,
	input  wire logic        mode64,
	// Register file read results for the base and index fields.
	output logic [4:0]       baseGprField,
	output logic [4:0]       indexGprField,
	input  wire logic [63:0] baseValue,
	input  wire logic [63:0] indexValue,
	// Data storage port.
	output logic             memReq,
	output logic [63:0]      memAddr,
	input  wire logic        memAck,
	input  wire logic [63:0] memData,
	input  wire logic        memAlignFault,
	input  wire logic        memStorageFault,
	// Register writeback.
	output logic             gprWe,
	output logic [4:0]       gprWaddr,
	output logic [63:0]      gprWdata,
	output logic             fprWe,
	output logic [4:0]       fprWaddr,
	output logic [63:0]      fprWdata,
	output logic             baseWe,
	output logic [4:0]       baseWaddr,
	output logic [63:0]      baseWdata,
	// Completion and exceptions.
	output logic             done,
	output logic             illegalInstr,
	output logic             invalidForm,
	output logic             alignInt,
	output logic             storageInt,
	output logic             fpscrWe,
	output logic             crField0We
);
	typedef struct packed {
		dwl_state_e state;
		dwl_kind_e  kind;
		logic       fpTarget;
		logic       wantUpdate;
		logic       baseZero;
		// Register fields and the address captured at issue.
		logic [4:0] tgt;
		logic [4:0] base;
		logic [63:0] addr;

		// Storage request, loaded word and the one-cycle pulses.
		logic       memReq;
		logic       gprWe;
		logic       fprWe;
		logic       baseWe;
		logic [63:0] data;
		logic       done;
		logic       illegal;
		logic       invalid;
		logic       alignInt;
		logic       storageInt;
	} dwl_unit_s;

	dwl_unit_s   st_q;
	dwl_unit_s   st_d;
	logic [63:0] ea;

	dwl_dec_if dec ();

	dwl_decode u_decode (
		.instr  (instr),
		.mode64 (mode64),
		.dec    (dec)
	);

	// Base contributes nothing when its field is zero.
	function automatic logic [63:0] baseTerm(input logic zero, input logic [63:0] v);
		return zero ? 64'h0000_0000_0000_0000 : v;
	endfunction

	assign baseGprField  = dec.baseGprField;
	assign indexGprField = dec.indexGprField;
	// Indexed forms use index, displacement forms the decoded displacement.
	assign ea = baseTerm(dec.baseZero, baseValue) + (dec.useIndex ? indexValue : dec.disp);
	assign issueReady = (st_q.state == DWL_S_IDLE);

	// One load walks through three states. The cycle after issue raises the storage
	// request with the address already registered, so the storage side sees a stable
	// address for as long as the request stands. The writeback pulses follow the
	// acknowledge by one cycle, and done follows the writebacks by one more, which
	// lets the pipeline see the loaded word before it retires the instruction.
	// Illegal and invalid forms answer in the cycle after issue and never leave idle,
	// so a second instruction may follow them at once.
	// Only one load is in flight; issue waits in idle, which trades throughput for a
	// sequencer that needs no tracking of outstanding requests.
	// The address is formed from the register values of the issue cycle, so the
	// register file must present them combinationally from the field outputs.

	always_comb begin
		st_d        = st_q;
		st_d.gprWe  = 1'b0;
		st_d.fprWe  = 1'b0;
		st_d.baseWe = 1'b0;
		st_d.done   = 1'b0;
		st_d.illegal    = 1'b0;
		st_d.invalid    = 1'b0;
		st_d.alignInt   = 1'b0;
		st_d.storageInt = 1'b0;
		unique case (st_q.state)
			DWL_S_IDLE: begin
				if (issueValid && dec.kind != DWL_K_NONE) begin
					st_d.kind       = dec.kind;
					st_d.fpTarget   = dec.fpTarget;
					st_d.wantUpdate = dec.wantUpdate;
					st_d.baseZero   = dec.baseZero;
					st_d.tgt        = dec.targetGprField;
					st_d.base       = dec.baseGprField;
					st_d.addr       = ea;
					if (dec.illegal) begin
						st_d.illegal = 1'b1;
						st_d.done    = 1'b1;
					end else if (dec.invalid) begin
						// Invalid forms never touch storage or registers.
						st_d.invalid = 1'b1;
						st_d.done    = 1'b1;
					end else begin
						st_d.memReq = 1'b1;
						st_d.state  = DWL_S_READ;
					end
				end
			end
			DWL_S_READ: begin
				if (memAck) begin
					st_d.memReq = 1'b0;
					st_d.state  = DWL_S_DONE;
					st_d.data   = memData;
					// A fault still ends the load through done, so the pipeline
					// can take the interrupt in order.
					st_d.alignInt   = memAlignFault;
					st_d.storageInt = memStorageFault;
					if (!memAlignFault && !memStorageFault) begin
						st_d.gprWe = !st_q.fpTarget;
						st_d.fprWe = st_q.fpTarget;
						// Base update only without fault and with nonzero base.
						st_d.baseWe = st_q.wantUpdate && !st_q.baseZero;
					end
				end
			end
			DWL_S_DONE: begin
				// Done trails the writebacks so the written word is visible first.
				st_d.done  = 1'b1;
				st_d.state = DWL_S_IDLE;
			end
			default: begin
				// One state code is unused; recover to idle if it ever appears.
				st_d.state = DWL_S_IDLE;
			end
		endcase
	end

	// Reset clears every pulse and leaves the unit idle and ready.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Every output but the two field outputs and the two status enables comes straight from the state register.
	assign memReq       = st_q.memReq;
	assign memAddr      = st_q.addr;

	// Both register files see the same target and data; only the enables differ.
	assign gprWe        = st_q.gprWe;
	assign gprWaddr     = st_q.tgt;
	assign gprWdata     = st_q.data;
	assign fprWe        = st_q.fprWe;
	assign fprWaddr     = st_q.tgt;
	assign fprWdata     = st_q.data;
	assign baseWe       = st_q.baseWe;
	assign baseWaddr    = st_q.base;
	assign baseWdata    = st_q.addr;

	// Completion flags are one-cycle pulses; the fault flags lead done by one cycle.
	assign done         = st_q.done;
	assign illegalInstr = st_q.illegal;
	assign invalidForm  = st_q.invalid;
	assign alignInt     = st_q.alignInt;
	assign storageInt   = st_q.storageInt;
	// These loads never write float status or condition field 0.
	assign fpscrWe      = 1'b0;
	assign crField0We   = 1'b0;
endmodule // dwl_load_unit

// file: verification/dwl_load_unit_chk.sv
// Assertion checker for the doubleword load unit, bound to its ports.
`timescale 1ns/1ps
module dwl_load_unit_chk (
	// Watched ports.
	input wire logic        mclk, resetn, issueValid, issueReady, mode64, done, memReq,
	input wire logic        memAck, memAlignFault, memStorageFault, gprWe, fprWe, baseWe,
	input wire logic        illegalInstr, invalidForm, fpscrWe, crField0We,
	input wire logic [31:0] instr,
	input wire logic [63:0] baseValue, memAddr, baseWdata
);
	logic        tk, bad, hit, flt;
	logic [63:0] eaQ;
	// A base field of zero or equal to the target makes an update form unusable.
	assign tk  = issueValid && issueReady && mode64;
	assign bad = instr[20:16] == 5'h00 || instr[20:16] == instr[25:21];
	assign hit = memReq && memAck;
	assign flt = memAlignFault || memStorageFault;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			eaQ <= 64'h0;
		else if (memReq)
			eaQ <= memAddr;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	AST_NO_STATUS: assert property (!fpscrWe && !crField0We)
		else $error("status write seen");
	AST_ILLEGAL: assert property (issueValid && issueReady && !mode64
		&& instr[31:26] == 6'h3A && !instr[1] |=> done && illegalInstr && !memReq)
		else $error("no illegal answer");
	AST_INV_DS: assert property (tk && instr[31:26] == 6'h3A && instr[1:0] == 2'h1
		&& bad |=> done && invalidForm && !memReq) else $error("update form not refused");
	AST_INV_X: assert property (tk && instr[31:26] == 6'h1F && instr[10:1] == 10'h035
		&& bad |=> done && invalidForm && !memReq) else $error("indexed form not refused");
	AST_DS_ADDR: assert property (tk && instr[31:26] == 6'h3A && !instr[1] && !bad
		|=> memReq && memAddr == $past(baseValue)
		+ {{48{$past(instr[15])}}, $past(instr[15:2]), 2'h0})
		else $error("scaled displacement address wrong");
	AST_ACK_WRITE: assert property (hit && !flt |=> (gprWe || fprWe) ##1 done)
		else $error("load result not written");
	AST_FAULT: assert property (hit && flt |=> !gprWe && !fprWe && !baseWe)
		else $error("register written after fault");
	AST_BASE_EA: assert property (baseWe |-> baseWdata == eaQ)
		else $error("base update is not the address");
endmodule // dwl_load_unit_chk
bind dwl_load_unit dwl_load_unit_chk u_chk (.*);

// file: verification/dwl_mem_model.sv
// Data storage model that answers after a set delay, with optional faults.
`timescale 1ns/1ps
module dwl_mem_model (
	// Storage port and bench controls.
	input wire logic        mclk, resetn, memReq, alignF, storF,
	input wire logic [3:0]  lat,
	input wire logic [63:0] memAddr,
	output logic            memAck, memAlignFault, memStorageFault,
	output logic [63:0]     memData
);
	logic [3:0] cnt;
	logic       hit;
	assign hit = memReq && !memAck && cnt >= lat;
	// Outside the answer cycle the data lines shift a pattern, so stale data never looks valid.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			{memAck, memAlignFault, memStorageFault, cnt} <= 7'h00;
			memData <= 64'h0;
		end else begin
			{memAck, memAlignFault, memStorageFault} <= {hit, hit & alignF, hit & storF};
			cnt <= (hit || !memReq) ? 4'h0 : cnt + 4'h1;
			memData <= hit ? ~memAddr : {memData[62:0], ~memData[63]};
		end
	end
endmodule // dwl_mem_model

// file: verification/dwl_load_unit_tb.sv
// Self-checking testbench for the doubleword load unit.
`timescale 1ns/1ps
module dwl_load_unit_tb;
	logic        mclk, resetn, issueValid, issueReady, mode64, memReq, memAck, done;
	logic        memAlignFault, memStorageFault, gprWe, fprWe, baseWe, fpscrWe, crField0We;
	logic        illegalInstr, invalidForm, alignInt, storageInt, alignF, storF;
	logic [3:0]  lat;
	logic [4:0]  baseGprField, indexGprField, gprWaddr, fprWaddr, baseWaddr, tA, bA;
	logic [8:0]  seen;
	logic [31:0] instr;
	logic [63:0] baseValue, indexValue, memAddr, memData, gprWdata, fprWdata, baseWdata;
	logic [63:0] ea, tD, bD;
	int          errors, tests_run;
	// Register zero reads nonzero, so adding it where zero is meant shows up.
	assign baseValue  = 64'({baseGprField, 12'h100});
	assign indexValue = 64'({indexGprField, 4'h8});
	dwl_load_unit dut (.*);
	dwl_mem_model mem (.*);
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		seen = seen | {memReq, gprWe, fprWe, baseWe, done & illegalInstr, done & invalidForm,
			alignInt, storageInt, done};
		if (memReq)
			ea = memAddr;
		if (gprWe)
			{tA, tD} = {gprWaddr, gprWdata};
		if (fprWe)
			{tA, tD} = {fprWaddr, fprWdata};
		if (baseWe)
			{bA, bD} = {baseWaddr, baseWdata};
	end
	function automatic logic [31:0] ds(input logic [4:0] b, input logic [15:0] d);
		return {6'h3A, 5'h02, b, d};
	endfunction
	function automatic logic [31:0] xf(input logic [4:0] b, input logic [9:0] x);
		return {6'h1F, 5'h02, b, 5'h07, x, 1'b0};
	endfunction
	task automatic ck(input string n, input logic [69:0] e, input logic [69:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic run(input logic [31:0] ins, input logic [8:0] s, input logic [63:0] e);
		seen = 9'h000;
		{ea, tA, tD, bA, bD} = 202'h0;
		@(posedge mclk);
		#1;
		ck("idle ready", 1'b1, issueReady);
		{instr, issueValid} = {ins, 1'b1};
		@(posedge mclk);
		#1;
		issueValid = 1'b0;
		ck("busy ready", !s[8], issueReady);
		for (int k = 0; k < 30 && !seen[0]; k++) begin
			@(posedge mclk);
			#1;
		end
		ck("flags", s, seen);
		if (s[8])
			ck("address", e, ea);
		if (s[7] | s[6])
			ck("target", {5'h02, ~e}, {tA, tD});
		if (s[5])
			ck("base", {ins[20:16], e}, {bA, bD});
	endtask
	task automatic t_fixed();
		run(ds(5'h05, {14'h3FFF, 2'h1}), 9'h1A1, 64'h50FC);
		lat = 4'h3;
		run(ds(5'h05, {14'h1FFF, 2'h0}), 9'h181, 64'hD0FC);
		run(xf(5'h00, 10'h015), 9'h181, 64'h78);
		run(xf(5'h05, 10'h015), 9'h181, 64'h5178);
		lat = 4'h0;
		run(xf(5'h06, 10'h035), 9'h1A1, 64'h6178);
	endtask
	task automatic t_invalid();
		run(ds(5'h00, 16'h0005), 9'h009, 64'h0);
		run(ds(5'h02, 16'h0005), 9'h009, 64'h0);
		run(xf(5'h00, 10'h035), 9'h009, 64'h0);
		run(xf(5'h02, 10'h035), 9'h009, 64'h0);
	endtask
	task automatic t_mode32();
		mode64 = 1'b0;
		run(ds(5'h00, 16'h0005), 9'h011, 64'h0);
		run(xf(5'h05, 10'h015), 9'h011, 64'h0);
		run(xf(5'h05, 10'h035), 9'h011, 64'h0);
		mode64 = 1'b1;
	endtask
	task automatic t_float();
		run({6'h32, 5'h02, 5'h05, 16'h8000}, 9'h141, 64'hFFFFFFFFFFFFD100);
		run({6'h32, 5'h02, 5'h00, 16'h7FF0}, 9'h141, 64'h7FF0);
		run({6'h33, 5'h02, 5'h05, 16'hFFF8}, 9'h161, 64'h50F8);
		run({6'h33, 5'h02, 5'h00, 16'h0010}, 9'h141, 64'h10);
		run(xf(5'h06, 10'h277), 9'h161, 64'h6178);
		run(xf(5'h00, 10'h277), 9'h141, 64'h78);
	endtask
	task automatic t_fault();
		alignF = 1'b1;
		run({6'h33, 5'h02, 5'h05, 16'h0008}, 9'h105, 64'h5108);
		{alignF, storF} = 2'h1;
		run(xf(5'h06, 10'h277), 9'h103, 64'h6178);
		storF = 1'b0;
	endtask
	task automatic final_report();
		if (errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		{resetn, issueValid, mode64, alignF, storF, lat, instr} = {5'h04, 4'h0, 32'h0};
		errors = 0;
		tests_run = 0;
		repeat (20) @(posedge mclk);
		#1;
		resetn = 1'b1;
		t_fixed();
		t_invalid();
		t_mode32();
		t_float();
		t_fault();
		final_report();
	end
	initial begin
		#200000;
		errors++;
		final_report();
	end
endmodule // dwl_load_unit_tb
